// [hdl/shm_delay.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Fixed-depth valid/data delay line
module shm_delay #(
  parameter int W     = 32,
  parameter int DEPTH = 3
) (
  input  wire logic         clk,       // Kernel clock
  input  wire logic         ce,        // Clock enable
  input  wire logic         clr,       // Synchronous clear
  input  wire logic         in_valid,  // Word enters stage 0
  input  wire logic [W-1:0] in_data,   // Word data
  output logic              out_valid, // Word leaves last stage
  output logic [W-1:0]      out_data   // Last stage data
);
  logic [DEPTH-1:0] vld_r;
  logic [DEPTH-1:0] vld_nxt;
  logic [W-1:0]     dat_r   [DEPTH];
  logic [W-1:0]     dat_nxt [DEPTH];

  generate
    if (DEPTH < 1) begin : g_chk
      $error("shm_delay: DEPTH must be at least 1");
    end
  endgenerate

  // Shift; data flops only load behind a valid word to save toggling
  always_comb begin
    vld_nxt    = (vld_r << 1) | DEPTH'(in_valid);
    dat_nxt[0] = in_valid ? in_data : dat_r[0];
    for (int i = 1; i < DEPTH; i++) begin
      dat_nxt[i] = vld_r[i-1] ? dat_r[i-1] : dat_r[i];
    end
    if (DEPTH == 1) begin
      vld_nxt = in_valid;
    end
    if (clr) begin
      vld_nxt = '0;
    end
  end

  // Register only
  always_ff @(posedge clk) begin
    if (ce) begin
      vld_r <= vld_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign out_valid = vld_r[DEPTH-1];
  assign out_data  = dat_r[DEPTH-1];
endmodule
`default_nettype wire

// [hdl/shm_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Synchronous FIFO with valid/ready on both sides
module shm_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,       // Kernel clock
  input  wire logic         ce,        // Clock enable
  input  wire logic         clr,       // Synchronous clear
  input  wire logic         in_valid,  // Push request
  output logic              in_ready,  // Not full
  input  wire logic [W-1:0] in_data,   // Push data
  output logic              out_valid, // Not empty
  input  wire logic         out_ready, // Pop request
  output logic [W-1:0]      out_data   // Head word
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wr_r;
  logic [AW:0]  rd_r;
  logic [AW:0]  wr_nxt;
  logic [AW:0]  rd_nxt;
  logic         push;
  logic         pop;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("shm_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  // Full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
  assign out_valid = (wr_r != rd_r);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_r[AW-1:0]];

  // Pointer next values
  always_comb begin
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    if (clr) begin
      wr_nxt = '0;
      rd_nxt = '0;
    end
  end

  // Register only; storage needs no clear
  always_ff @(posedge clk) begin
    if (ce) begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      if (push) begin
        mem_r[wr_r[AW-1:0]] <= in_data;
      end
    end
  end
endmodule
`default_nettype wire

// [hdl/shm_helper.sv]
// Overview of operation
// [RQ1] One input stream; all operands share one valid/ready pair.
// [RQ2] Ports: clock, active-low reset, ivalid, ovalid, iready, oready.
// [RQ3] All operands arrive together; one ivalid qualifies them all.
// [RQ4] Internal state holds whenever ivalid is low. Only the accumulator holds here; the delay line and FIFO still move.
// [RQ5] Behaviour counts clock cycles only, never absolute time.
// [RQ6] No device pins; every port faces surrounding kernel logic.
// [RQ7] Each instance is independent; nothing is shared.
// [RQ8] Result leaves on the output stream, configured width.
// [RQ9] Stall-free: fixed latency, input every cycle, iready ignored.
// [RQ10] Stall-free: synchronous clears only.
// [RQ11] Stall-free: operational within 15 cycles of reset release.
// [RQ12] Stallable: variable latency, backpressure honoured both sides.
// [RQ13] Stallable: synchronous clears only.
// [RQ14] Stallable: oready and ovalid low within 40 cycles of reset.
// [RQ15] Stallable: operational within 40 cycles, signalled by oready.
// [RQ16] Reset is active low.
// [RQ17] Operands are concatenated into one input data word.
// [RQ18] Fixed latency pipeline depth equals the declared latency.
// [RQ19] Transfer only when valid and ready; ovalid only on real results.
// [RQ20] Results leave in acceptance order.
`include "shm_regs.svh"
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Stream helper: odata = a * b + c, optionally accumulated
module shm_helper #(
  parameter int A_W                     = 32,
  parameter int B_W                     = 32,
  parameter int C_W                     = 32,
  parameter int OUT_W                   = 32,
  parameter int LATENCY                 = `SHM_LATENCY_DFLT,
  parameter int ACCUM                   = 0,
  parameter int RESET_STAGES            = `SHM_RESET_STAGES,
  parameter int FIFO_DEPTH              = `SHM_FIFO_DEPTH,
  parameter int no_backpressure_setting = 1,
  parameter int constant_delay_setting  = 1
) (
  input  wire logic                     ref_clk, // Kernel clock, see [RQ2]
  input  wire logic                     reset_n, // Reset, active low
  input  wire logic                     ce,      // Clock enable
  input  wire logic                     ivalid,  // Operand word valid
  output logic                          oready,  // Ready for operands
  input  wire logic [A_W+B_W+C_W-1:0]   idata,   // {c, b, a}
  output logic                          ovalid,  // Result valid
  input  wire logic                     iready,  // Downstream ready
  output logic [OUT_W-1:0]              odata    // Result
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  // =====================================================================
  // Elaboration checks
  generate
    if (LATENCY < 1) begin : g_chk_lat
      $error("shm_helper: LATENCY must be at least 1");
    end
    if (RESET_STAGES < 1) begin : g_chk_rs
      $error("shm_helper: RESET_STAGES must be at least 1");
    end
    if (no_backpressure_setting != 0 && constant_delay_setting == 0) begin : g_chk_sf
      $error("shm_helper: a stall-free build must be fixed latency");
    end
    if (no_backpressure_setting == 0 && constant_delay_setting != 0) begin : g_chk_sl
      $error("shm_helper: stallable build supports variable latency only");
    end
    if (no_backpressure_setting != 0 && RESET_STAGES + 1 > `SHM_SF_RESET_MAX) begin : g_chk_sfr
      $error("shm_helper: reset pipeline too deep for stall-free build");
    end
    if (no_backpressure_setting == 0 && RESET_STAGES + 1 > `SHM_SL_RESET_MAX) begin : g_chk_slr
      $error("shm_helper: reset pipeline too deep for stallable build");
    end
  endgenerate

  // =====================================================================
  // Reset pipeline and run state
  logic [RESET_STAGES-1:0] rst_pipe_r;
  logic [RESET_STAGES-1:0] rst_pipe_nxt;
  shm_pkg::shm_run_t       run_st_r;
  shm_pkg::shm_run_t       run_st_nxt;
  logic                    clr;
  logic                    run;

  // Clears are synchronous so the kernel reset tree stays flop-friendly
  always_comb begin
    rst_pipe_nxt = (rst_pipe_r << 1) | RESET_STAGES'(reset_n); // see [RQ16]
    unique case (run_st_r)
      shm_pkg::SHM_HOLD: begin
        run_st_nxt = rst_pipe_r[RESET_STAGES-1] ? shm_pkg::SHM_RUN : shm_pkg::SHM_HOLD;
      end
      shm_pkg::SHM_RUN: begin
        run_st_nxt = rst_pipe_r[RESET_STAGES-1] ? shm_pkg::SHM_RUN : shm_pkg::SHM_HOLD;
      end
    endcase
  end

  // Depth bounded so recovery fits in the cycle limit
  always_ff @(posedge ref_clk) begin // see [RQ10] see [RQ13] see [RQ11]
    if (ce) begin
      rst_pipe_r <= rst_pipe_nxt;
      run_st_r   <= run_st_nxt;
    end
  end

  // Run state is the only reset that reaches the datapath
  assign run = (run_st_r == shm_pkg::SHM_RUN);
  assign clr = !run;

  // =====================================================================
  // Operand split and compute
  logic [OUT_W-1:0] op_a;
  logic [OUT_W-1:0] op_b;
  logic [OUT_W-1:0] op_c;
  logic [OUT_W-1:0] prod;
  logic [OUT_W-1:0] result;
  logic [OUT_W-1:0] acc_r;
  logic [OUT_W-1:0] acc_nxt;
  logic             accept;

  // One word carries every operand, first operand lowest
  always_comb begin
    op_a = '0;
    op_b = '0;
    op_c = '0;
    op_a[A_W-1:0] = idata[A_W-1:0];             // see [RQ17] see [RQ3]
    op_b[B_W-1:0] = idata[A_W+B_W-1:A_W];       // see [RQ1]
    op_c[C_W-1:0] = idata[A_W+B_W+C_W-1:A_W+B_W];
  end

  // Product truncated to the result width on purpose
  assign prod   = op_a * op_b + op_c;
  assign accept = ivalid && oready; // see [RQ19]

  // Accumulator moves only on an accepted word or a clear
  always_comb begin
    acc_nxt = acc_r;
    if (accept && ACCUM != 0) begin // see [RQ4]
      acc_nxt = acc_r + prod;
    end
    if (clr) begin
      acc_nxt = `SHM_ACC_RESET;
    end
    result = (ACCUM != 0) ? acc_r + prod : prod;
  end

  // Private per instance, never merged
  always_ff @(posedge ref_clk) begin // see [RQ7]
    if (ce) begin
      acc_r <= acc_nxt;
    end
  end

  // =====================================================================
  // Fixed-depth pipeline, one flop stage per latency cycle
  logic             pipe_v;
  logic [OUT_W-1:0] pipe_d;

  shm_delay #(
    .W     (OUT_W),
    .DEPTH (LATENCY)
  ) u_delay ( // see [RQ18] see [RQ20] see [RQ5]
    .clk       (ref_clk),
    .ce        (ce),
    .clr       (clr),
    .in_valid  (accept),
    .in_data   (result),
    .out_valid (pipe_v),
    .out_data  (pipe_d)
  );

  // =====================================================================
  // Output side, per flavour
  generate
    if (no_backpressure_setting != 0) begin : g_stall_free
      // Pipeline never stalls, so iready has no effect
      assign oready = run;                 // see [RQ9]
      assign ovalid = pipe_v && run;       // see [RQ6]
      assign odata  = pipe_d;              // see [RQ8]
    end else begin : g_stallable
      logic          fifo_in_rdy;
      logic          fifo_ov;
      logic          pop;
      logic [CW-1:0] cnt_r;
      logic [CW-1:0] cnt_nxt;

      // Credits count words in the pipe plus the FIFO, so the pipe can
      // keep flowing while the FIFO absorbs downstream stalls
      assign pop    = fifo_ov && iready && run;
      assign oready = run && fifo_in_rdy && (cnt_r < CW'(FIFO_DEPTH)); // see [RQ12] see [RQ15]
      assign ovalid = fifo_ov && run;       // see [RQ14] see [RQ19]

      always_comb begin
        cnt_nxt = cnt_r + CW'(accept) - CW'(pop);
        if (clr) begin
          cnt_nxt = `SHM_CNT_RESET;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (ce) begin
          cnt_r <= cnt_nxt;
        end
      end

      shm_fifo #(
        .W     (OUT_W),
        .DEPTH (FIFO_DEPTH)
      ) u_fifo ( // see [RQ20] see [RQ8]
        .clk       (ref_clk),
        .ce        (ce),
        .clr       (clr),
        .in_valid  (pipe_v),
        .in_ready  (fifo_in_rdy),
        .in_data   (pipe_d),
        .out_valid (fifo_ov),
        .out_ready (iready && run),
        .out_data  (odata)
      );
    end
  endgenerate
endmodule
`default_nettype wire

// [hdl/shm_pkg.sv]
// =====================================================================
// Shared types
package shm_pkg;
  // Run state of the helper
  typedef enum {
    SHM_HOLD,
    SHM_RUN
  } shm_run_t;
endpackage

// [hdl/shm_regs.svh]
`ifndef SHM_REGS_SVH
`define SHM_REGS_SVH
// =====================================================================
// Timing limits, counted in kernel clock cycles
`define SHM_SF_RESET_MAX 15
`define SHM_SL_RESET_MAX 40
// =====================================================================
// Structural defaults
`define SHM_LATENCY_DFLT 3
`define SHM_RESET_STAGES 3
`define SHM_FIFO_DEPTH 32
// =====================================================================
// Reset values
`define SHM_ACC_RESET '0
`define SHM_CNT_RESET '0
`endif

// [tb/shm_chk_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ====================
// Port checks for the stream helper
module shm_chk #(
  parameter int A_W        = 32,
  parameter int B_W        = 32,
  parameter int C_W        = 32,
  parameter int OUT_W      = 32,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic                   ref_clk, // Kernel clock
  input wire logic                   reset_n, // Reset, active low
  input wire logic                   ce,      // Clock enable
  input wire logic                   ivalid,  // Operand valid
  input wire logic                   oready,  // Ready upstream
  input wire logic [A_W+B_W+C_W-1:0] idata,   // Operands
  input wire logic                   ovalid,  // Result valid
  input wire logic                   iready,  // Downstream ready
  input wire logic [OUT_W-1:0]       odata    // Result
);
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  // Words owed downstream, in flight or buffered
  always_comb begin
    cnt_nxt = cnt_r;
    if (ce && ivalid && oready) cnt_nxt = cnt_nxt + 8'h01;
    if (ce && ovalid && iready) cnt_nxt = cnt_nxt - 8'h01;
    if (!reset_n) cnt_nxt = 8'h00;
  end
  // Counter register
  always_ff @(posedge ref_clk) begin
    cnt_r <= cnt_nxt;
  end
  sequence s_take_empty;
    ce && ivalid && oready && cnt_r == 8'h00;
  endsequence
  sequence s_quiet3;
    !ovalid [*3];
  endsequence
  // Three enabled cycles with no intake leave the pipe empty
  sequence s_flowing;
    (ce && !(ivalid && oready)) [*3];
  endsequence
  // No disable here: the rule is about behaviour during reset
  AST_RST_QUIET: assert property (@(posedge ref_clk)
    $fell(reset_n) |-> ##[0:40] (!oready && !ovalid)) else $error("outputs not idle in reset");
  AST_RST_READY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n) |-> ##[1:40] oready) else $error("ready late after reset");
  AST_RST_EMPTY: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(reset_n) |-> !ovalid) else $error("result valid right after reset");
  AST_HOLD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ovalid && !(iready && ce) |=> ovalid && $stable(odata)) else $error("result dropped");
  AST_NO_GHOST: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cnt_r == 8'h00 |-> !ovalid) else $error("result with nothing owed");
  AST_FULL_REFUSE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cnt_r == FIFO_DEPTH |-> !oready) else $error("ready while full");
  AST_FIRST_LAT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_take_empty |=> s_quiet3) else $error("result before pipeline depth");
  AST_LIVE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_flowing |-> (cnt_r == 8'h00 || ovalid)) else $error("owed result never offered");
endmodule
bind shm_helper shm_chk #(.A_W(A_W), .B_W(B_W), .C_W(C_W), .OUT_W(OUT_W),
  .FIFO_DEPTH(FIFO_DEPTH)) chk_u (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
  .ivalid(ivalid), .oready(oready), .idata(idata), .ovalid(ovalid), .iready(iready),
  .odata(odata));
`default_nettype wire

// [tb/shm_sink.sv]
`timescale 1ns/1ps
`default_nettype none
// ====================
// Downstream pipeline model: takes results under a stall pattern
module shm_sink #(
  parameter int OUT_W = 16
) (
  input  wire logic             ref_clk, // Kernel clock
  input  wire logic             ce,      // Clock enable
  input  wire logic             ovalid,  // Result valid
  input  wire logic [OUT_W-1:0] odata,   // Result
  input  wire logic [1:0]       mode,    // 0 ready, 1 stall, 2 alternate
  output logic                  iready   // Ready to take
);
  logic [OUT_W-1:0] got[$];
  logic             tog = 1'b0;
  initial iready = 1'b0;
  // Take only on valid and ready; change ready after the edge
  always @(posedge ref_clk) begin
    if (ce && ovalid && iready) got.push_back(odata);
    tog = !tog;
    #2;
    iready = (mode == 2'h0) || (mode == 2'h2 && tog);
  end
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// ====================
// Stallable build, accumulating, small operands
module testbench;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        ce      = 1'b1;
  logic        ivalid  = 1'b0;
  logic [23:0] idata   = 24'h000000;
  logic [1:0]  mode    = 2'h0;
  logic        oready;
  logic        ovalid;
  logic        iready;
  logic [15:0] odata;
  logic [15:0] acc;
  logic [15:0] exp_q[$];
  int          num_errors  = 0;
  int          checks_done = 0;
  int          n;
  localparam int OPW = 8;
  localparam int RW  = 16;
  always #20 ref_clk = !ref_clk;
  shm_helper #(.A_W(OPW), .B_W(OPW), .C_W(OPW), .OUT_W(RW), .ACCUM(1),
    .no_backpressure_setting(0), .constant_delay_setting(0)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .ivalid(ivalid), .oready(oready),
    .idata(idata), .ovalid(ovalid), .iready(iready), .odata(odata));
  shm_sink #(.OUT_W(RW)) sink_u (.ref_clk(ref_clk), .ce(ce), .ovalid(ovalid),
    .odata(odata), .mode(mode), .iready(iready));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  // A hang counts as a mismatch
  task automatic timeout;
    check(16'h0000, 16'h0001);
    stop_test();
  endtask
  // Holds the word until taken; leaves ivalid up for back-to-back use
  task automatic send(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    ivalid = 1'b1;
    idata = {c, b, a};
    n = 0;
    // Ready is judged settled, before the edge that takes the word
    while (!(oready && ce) && n < 200) begin
      tick();
      n++;
    end
    if (n == 200) timeout();
    tick();
    acc = acc + a * b + c;
    exp_q.push_back(acc);
  endtask
  task automatic drain;
    for (n = 0; n < 2000 && sink_u.got.size() < exp_q.size(); n++) tick();
    if (n == 2000) timeout();
    repeat (6) tick();
    check(16'(sink_u.got.size()), 16'(exp_q.size()));
    while (exp_q.size() > 0) check(sink_u.got.pop_front(), exp_q.pop_front());
  endtask
  task automatic do_reset;
    reset_n = 1'b0;
    repeat (16) tick();
    check(oready, 1'b0);
    check(ovalid, 1'b0);
    reset_n = 1'b1;
    for (n = 0; n < 40 && !oready; n++) tick();
    check(oready, 1'b1);
    acc = 16'h0000;
    exp_q.delete();
    sink_u.got.delete();
  endtask
  // Back-to-back words, idle gaps and a clock-enable pause
  task automatic test_basic;
    mode = 2'h2;
    send(8'h03, 8'h05, 8'h07);
    send(8'hff, 8'hff, 8'hff);
    send(8'h10, 8'h02, 8'h01);
    ivalid = 1'b0;
    repeat (4) tick();
    ce = 1'b0;
    repeat (3) tick();
    ce = 1'b1;
    send(8'h00, 8'h09, 8'h80);
    send(8'h0c, 8'h0d, 8'h00);
    ivalid = 1'b0;
    drain();
    $display("test basic done");
  endtask
  // Fill with downstream stalled until refused, then drain
  task automatic test_fill;
    int k;
    mode = 2'h1;
    ivalid = 1'b1;
    for (k = 0; k < 40; k++) begin
      idata = {k[7:0], 8'h03, 8'hfe};
      // Settled ready decides whether the coming edge takes the word
      if (oready) begin
        acc = acc + 16'h02fa + 16'(k);
        exp_q.push_back(acc);
      end
      tick();
    end
    check(16'(exp_q.size()), 16'h0020);
    check(oready, 1'b0);
    ivalid = 1'b0;
    mode = 2'h0;
    drain();
    $display("test fill done");
  endtask
  // Reset with work in flight: nothing stale comes out afterwards
  task automatic test_mid_reset;
    mode = 2'h1;
    send(8'h01, 8'h01, 8'h01);
    send(8'h02, 8'h02, 8'h02);
    ivalid = 1'b0;
    repeat (6) tick();
    do_reset();
    mode = 2'h0;
    send(8'h02, 8'h03, 8'h04);
    ivalid = 1'b0;
    drain();
    $display("test mid reset done");
  endtask
  initial begin
    do_reset();
    test_basic();
    test_fill();
    test_mid_reset();
    stop_test();
  end
endmodule
`default_nettype wire
